// ### abcfg_top.sv
// Summary of operation
// - Step enable bit includes last sequencer step
// - Step gain: 00 one, 01 two, else four
// - Negative select: ground or input seven
// - Codes 0-7 external inputs, 8 temperature
// - Codes 8 and up pick negative automatically
// - Short, test DAC, analog/digital rails on codes 9, 10, 14, 15
// - Result zero when disabled, standby, power-down
// - Counter cleared while both converters disabled
// - Voltage converter gain: one, two, four
// - Mux: normal, swapped, shorted, test DAC
// - Bit 5 steers open-wire source pin
// - Bit 4 steers open-wire sink pin
// - Source magnitude: off, 4, 40, 240 uA
// - Sink magnitude uses same encoding
// - Converter register at E0h, reset 8010h
// - Last-step register at DFh, reset 000Fh
//
// The strobed register port was left to the implementer.
`default_nettype none

module abcfg_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o,
	input  wire logic        standby_i,
	input  wire logic        powerdown_i,
	input  wire logic        current_conv_b_en_i,
	input  wire logic [23:0] vconv_data_i,
	input  wire logic        vconv_data_valid_i,
	input  wire logic        conv_tick_i,
	output logic             step_enable_o,
	output logic      [2:0]  step_gain_o,
	output logic      [3:0]  step_pos_sel_o,
	output logic      [2:0]  step_src_o,
	output logic             step_neg_auto_o,
	output logic             step_neg_seven_o,
	output logic             vconv_enable_o,
	output logic      [2:0]  vconv_gain_o,
	output logic      [3:0]  vconv_mux_o,
	output logic             ow_source_pin_o,
	output logic             ow_sink_pin_o,
	output logic      [7:0]  ow_source_ua_o,
	output logic      [7:0]  ow_sink_ua_o,
	output logic      [23:0] vconv_result_o,
	output logic      [1:0]  conv_count_o
);

	// ----------------------------------------------------------------
	// Register storage and next values
	// ----------------------------------------------------------------
	logic [15:0] step_cfg;
	logic [15:0] vconv_cfg;
	logic [15:0] next_step_cfg;
	logic [15:0] next_vconv_cfg;
	logic [2:0]  next_step_gain;
	logic [2:0]  next_vconv_gain;
	logic [3:0]  next_pos;
	logic [1:0]  next_mux;
	logic        wr_step;
	logic        wr_vconv;

	// Checks below sample on the rising edge, idle during reset
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Write decode
	always_comb begin
		wr_step  = 1'b0;
		wr_vconv = 1'b0;
		if (wr_i && addr_i == abcfg_pkg::ADDR_STEP_CFG) begin
			wr_step = 1'b1;
		end else if (wr_i && addr_i == abcfg_pkg::ADDR_VCONV_CFG) begin
			wr_vconv = 1'b1;
		end
	end

	// Masked next values; reserved bits never stored
	always_comb begin
		next_step_cfg  = step_cfg;
		next_vconv_cfg = vconv_cfg;
		if (wr_step) begin
			next_step_cfg = wdata_i & abcfg_pkg::STEP_CFG_WMASK;
		end
		if (wr_vconv) begin
			next_vconv_cfg = wdata_i & abcfg_pkg::VCONV_CFG_WMASK;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	// Last-step register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			step_cfg <= abcfg_pkg::STEP_CFG_RESET;
		end else begin
			step_cfg <= next_step_cfg;
		end
	end

	// Voltage converter register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vconv_cfg <= abcfg_pkg::VCONV_CFG_RESET;
		end else begin
			vconv_cfg <= next_vconv_cfg;
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	// Data valid only in the cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= abcfg_pkg::DATA_ZERO;
		end else if (rd_i && addr_i == abcfg_pkg::ADDR_STEP_CFG) begin
			rdata_o <= step_cfg;
		end else if (rd_i && addr_i == abcfg_pkg::ADDR_VCONV_CFG) begin
			rdata_o <= vconv_cfg;
		end else begin
			rdata_o <= abcfg_pkg::DATA_ZERO;
		end
	end

	// ----------------------------------------------------------------
	// Gain decoders
	// ----------------------------------------------------------------
	abcfg_gain_dec u_step_gain (
		.code_i (next_step_cfg[abcfg_pkg::STEP_GAIN_LSB +: 2]),
		.gain_o (next_step_gain)
	);

	abcfg_gain_dec u_vconv_gain (
		.code_i (next_vconv_cfg[abcfg_pkg::VC_GAIN_LSB +: 2]),
		.gain_o (next_vconv_gain)
	);

	assign next_pos = next_step_cfg[abcfg_pkg::STEP_POS_LSB +: 4];
	assign next_mux = next_vconv_cfg[abcfg_pkg::VC_MUX_LSB +: 2];

	// ----------------------------------------------------------------
	// Sequencer last-step controls
	// ----------------------------------------------------------------
	// Step controls track the register in the same edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			step_enable_o    <= abcfg_pkg::STEP_CFG_RESET[abcfg_pkg::STEP_EN_BIT];
			step_gain_o      <= abcfg_pkg::GAIN_X1;
			step_pos_sel_o   <= abcfg_pkg::POS_DIGITAL_RAIL;
			step_src_o       <= abcfg_pkg::SRC_DIGITAL_RAIL;
			step_neg_auto_o  <= 1'b1;
			step_neg_seven_o <= 1'b0;
		end else begin
			step_enable_o    <= next_step_cfg[abcfg_pkg::STEP_EN_BIT];
			step_gain_o      <= next_step_gain;
			step_pos_sel_o   <= next_pos;
			step_src_o       <= abcfg_pkg::abcfg_src_kind(next_pos);
			step_neg_auto_o  <= next_pos[3];
			// Negative select only counts for external codes
			step_neg_seven_o <= !next_pos[3] && next_step_cfg[abcfg_pkg::STEP_NEG_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Voltage converter controls
	// ----------------------------------------------------------------
	// Enable, gain and one-hot input routing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vconv_enable_o <= abcfg_pkg::VCONV_CFG_RESET[abcfg_pkg::VC_EN_BIT];
			vconv_gain_o   <= abcfg_pkg::GAIN_X1;
			vconv_mux_o    <= 4'h1;
		end else begin
			vconv_enable_o <= next_vconv_cfg[abcfg_pkg::VC_EN_BIT];
			vconv_gain_o   <= next_vconv_gain;
			vconv_mux_o    <= 4'h1 << next_mux;
		end
	end

	// Open-wire test current routing and magnitudes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ow_source_pin_o <= abcfg_pkg::VCONV_CFG_RESET[abcfg_pkg::OW_SRC_PIN_BIT];
			ow_sink_pin_o   <= abcfg_pkg::VCONV_CFG_RESET[abcfg_pkg::OW_SNK_PIN_BIT];
			ow_source_ua_o  <= abcfg_pkg::UA_OFF;
			ow_sink_ua_o    <= abcfg_pkg::UA_OFF;
		end else begin
			ow_source_pin_o <= next_vconv_cfg[abcfg_pkg::OW_SRC_PIN_BIT];
			ow_sink_pin_o   <= next_vconv_cfg[abcfg_pkg::OW_SNK_PIN_BIT];
			ow_source_ua_o  <= abcfg_pkg::abcfg_mag_ua(
				next_vconv_cfg[abcfg_pkg::OW_SRC_MAG_LSB +: 2]);
			ow_sink_ua_o    <= abcfg_pkg::abcfg_mag_ua(
				next_vconv_cfg[abcfg_pkg::OW_SNK_MAG_LSB +: 2]);
		end
	end

	// ----------------------------------------------------------------
	// Conversion result and counter
	// ----------------------------------------------------------------
	// Result held at zero while converter may not run
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vconv_result_o <= abcfg_pkg::RESULT_ZERO;
		end else if (!vconv_enable_o || standby_i || powerdown_i) begin
			vconv_result_o <= abcfg_pkg::RESULT_ZERO;
		end else if (vconv_data_valid_i) begin
			vconv_result_o <= vconv_data_i;
		end
	end

	// Counter wraps; clear wins over count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conv_count_o <= 2'h0;
		end else if (!vconv_enable_o && !current_conv_b_en_i) begin
			conv_count_o <= 2'h0;
		end else if (conv_tick_i) begin
			conv_count_o <= conv_count_o + 2'h1;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_wr_step;
		wr_i && addr_i == abcfg_pkg::ADDR_STEP_CFG;
	endsequence

	sequence s_wr_vconv;
		wr_i && addr_i == abcfg_pkg::ADDR_VCONV_CFG;
	endsequence

	sequence s_rd_step;
		rd_i && addr_i == abcfg_pkg::ADDR_STEP_CFG;
	endsequence

	property p_step_enable;
		s_wr_step |=> step_enable_o == $past(wdata_i[15]);
	endproperty
	a_step_enable: assert property (p_step_enable)
		else $error("step enable does not follow write");

	property p_step_gain;
		s_wr_step |=> step_gain_o == ($past(wdata_i[14:13]) == 2'h0 ? 3'h1 :
			($past(wdata_i[14:13]) == 2'h1 ? 3'h2 : 3'h4));
	endproperty
	a_step_gain: assert property (p_step_gain)
		else $error("step gain decode wrong");

	property p_neg_select;
		s_wr_step ##1 !step_neg_auto_o |-> step_neg_seven_o == $past(wdata_i[4]);
	endproperty
	a_neg_select: assert property (p_neg_select)
		else $error("negative select not honoured");

	property p_pos_external;
		s_wr_step and wdata_i[3] == 1'b0 |=> step_src_o == 3'h0 && !step_neg_auto_o;
	endproperty
	a_pos_external: assert property (p_pos_external)
		else $error("external code not routed");

	property p_neg_auto;
		step_pos_sel_o >= 4'h8 |-> step_neg_auto_o && !step_neg_seven_o;
	endproperty
	a_neg_auto: assert property (p_neg_auto)
		else $error("negative select used for internal source");

	property p_rails;
		s_wr_step and wdata_i[3:0] == 4'he |=> step_src_o == 3'h4 ##1
			(step_src_o == 3'h4 || $past(wr_step));
	endproperty
	a_rails: assert property (p_rails)
		else $error("analog rail source not selected");

	property p_result_zero;
		(!vconv_enable_o || standby_i || powerdown_i) |=> vconv_result_o == 24'h000000;
	endproperty
	a_result_zero: assert property (p_result_zero)
		else $error("result not forced to zero");

	property p_count_clear;
		!vconv_enable_o && !current_conv_b_en_i |=> conv_count_o == 2'h0;
	endproperty
	a_count_clear: assert property (p_count_clear)
		else $error("conversion counter not cleared");

	property p_vconv_gain;
		s_wr_vconv and wdata_i[11:10] == 2'h3 |=> vconv_gain_o == 3'h4;
	endproperty
	a_vconv_gain: assert property (p_vconv_gain)
		else $error("converter gain decode wrong");

	property p_mux;
		s_wr_vconv |=> vconv_mux_o == (4'h1 << $past(wdata_i[9:8])) && $onehot(vconv_mux_o);
	endproperty
	a_mux: assert property (p_mux)
		else $error("converter input mux wrong");

	property p_ow_pins;
		s_wr_vconv |=> ow_source_pin_o == $past(wdata_i[5]) &&
			ow_sink_pin_o == $past(wdata_i[4]);
	endproperty
	a_ow_pins: assert property (p_ow_pins)
		else $error("open-wire pin steering wrong");

	property p_ow_mag;
		s_wr_vconv and wdata_i[3:0] == 4'hb |=> ow_source_ua_o == 8'h28 &&
			ow_sink_ua_o == 8'hf0;
	endproperty
	a_ow_mag: assert property (p_ow_mag)
		else $error("open-wire magnitude wrong");

	property p_ow_sink_low;
		s_wr_vconv and wdata_i[1:0] == 2'h1 |=> ow_sink_ua_o == 8'h04;
	endproperty
	a_ow_sink_low: assert property (p_ow_sink_low)
		else $error("open-wire sink magnitude wrong");

	property p_vconv_enable;
		s_wr_vconv |=> vconv_enable_o == $past(wdata_i[15]);
	endproperty
	a_vconv_enable: assert property (p_vconv_enable)
		else $error("converter enable does not follow write");

	property p_step_pos;
		s_wr_step |=> step_pos_sel_o == $past(wdata_i[3:0]);
	endproperty
	a_step_pos: assert property (p_step_pos)
		else $error("positive select does not follow write");

	property p_reset_values;
		$fell(rst_i) |-> vconv_cfg == 16'h8010 && step_cfg == 16'h000f &&
			ow_sink_pin_o && vconv_enable_o && !step_enable_o;
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("register reset values wrong");

	property p_reserved;
		s_rd_step |=> rdata_o[12:5] == 8'h00 && rdata_o == $past(step_cfg);
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved bits read nonzero");

	property p_read_gap;
		!$past(rd_i) |-> rdata_o == 16'h0000;
	endproperty
	a_read_gap: assert property (p_read_gap)
		else $error("read data outside its cycle");

endmodule

`default_nettype wire

// ### abcfg_pkg.sv
`default_nettype none

package abcfg_pkg;

	// ----------------------------------------------------------------
	// Bus widths and addresses
	// ----------------------------------------------------------------
	localparam int          ABCFG_AW         = 8;
	localparam int          ABCFG_DW         = 16;
	localparam int          ABCFG_RESULT_W   = 24;
	localparam logic [7:0]  ADDR_STEP_CFG    = 8'hdf;
	localparam logic [7:0]  ADDR_VCONV_CFG   = 8'he0;

	// ----------------------------------------------------------------
	// Reset values and writable-bit masks
	// ----------------------------------------------------------------
	localparam logic [15:0] STEP_CFG_RESET   = 16'h000f;
	localparam logic [15:0] VCONV_CFG_RESET  = 16'h8010;
	localparam logic [15:0] STEP_CFG_WMASK   = 16'he01f;
	localparam logic [15:0] VCONV_CFG_WMASK  = 16'h8f3f;
	localparam logic [15:0] DATA_ZERO        = 16'h0000;
	localparam logic [23:0] RESULT_ZERO      = 24'h000000;

	// ----------------------------------------------------------------
	// Sequencer last-step field positions
	// ----------------------------------------------------------------
	localparam int          STEP_EN_BIT      = 15;
	localparam int          STEP_GAIN_LSB    = 13;
	localparam int          STEP_NEG_BIT     = 4;
	localparam int          STEP_POS_LSB     = 0;

	// ----------------------------------------------------------------
	// Voltage converter field positions
	// ----------------------------------------------------------------
	localparam int          VC_EN_BIT        = 15;
	localparam int          VC_GAIN_LSB      = 10;
	localparam int          VC_MUX_LSB       = 8;
	localparam int          OW_SRC_PIN_BIT   = 5;
	localparam int          OW_SNK_PIN_BIT   = 4;
	localparam int          OW_SRC_MAG_LSB   = 2;
	localparam int          OW_SNK_MAG_LSB   = 0;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	localparam logic [1:0]  GAIN_CODE_X1     = 2'h0;
	localparam logic [1:0]  GAIN_CODE_X2     = 2'h1;
	localparam logic [2:0]  GAIN_X1          = 3'h1;
	localparam logic [2:0]  GAIN_X2          = 3'h2;
	localparam logic [2:0]  GAIN_X4          = 3'h4;
	localparam logic [3:0]  POS_TEMP         = 4'h8;
	localparam logic [3:0]  POS_SHORT        = 4'h9;
	localparam logic [3:0]  POS_TEST_DAC     = 4'ha;
	localparam logic [3:0]  POS_ANALOG_RAIL  = 4'he;
	localparam logic [3:0]  POS_DIGITAL_RAIL = 4'hf;
	localparam logic [2:0]  SRC_EXTERNAL     = 3'h0;
	localparam logic [2:0]  SRC_TEMP         = 3'h1;
	localparam logic [2:0]  SRC_SHORT        = 3'h2;
	localparam logic [2:0]  SRC_TEST_DAC     = 3'h3;
	localparam logic [2:0]  SRC_ANALOG_RAIL  = 3'h4;
	localparam logic [2:0]  SRC_DIGITAL_RAIL = 3'h5;
	localparam logic [2:0]  SRC_OTHER        = 3'h6;
	localparam logic [1:0]  MAG_OFF          = 2'h0;
	localparam logic [1:0]  MAG_LOW          = 2'h1;
	localparam logic [1:0]  MAG_MID          = 2'h2;
	localparam logic [7:0]  UA_OFF           = 8'h00;
	localparam logic [7:0]  UA_LOW           = 8'h04;
	localparam logic [7:0]  UA_MID           = 8'h28;
	localparam logic [7:0]  UA_HIGH          = 8'hf0;

	// Magnitude code to microamperes
	function automatic logic [7:0] abcfg_mag_ua(input logic [1:0] code);
		logic [7:0] ua;
		ua = UA_HIGH;
		if (code == MAG_OFF) begin
			ua = UA_OFF;
		end else if (code == MAG_LOW) begin
			ua = UA_LOW;
		end else if (code == MAG_MID) begin
			ua = UA_MID;
		end
		return ua;
	endfunction

	// Positive select code to source kind
	function automatic logic [2:0] abcfg_src_kind(input logic [3:0] code);
		logic [2:0] kind;
		kind = SRC_OTHER;
		if (code < POS_TEMP) begin
			kind = SRC_EXTERNAL;
		end else if (code == POS_TEMP) begin
			kind = SRC_TEMP;
		end else if (code == POS_SHORT) begin
			kind = SRC_SHORT;
		end else if (code == POS_TEST_DAC) begin
			kind = SRC_TEST_DAC;
		end else if (code == POS_ANALOG_RAIL) begin
			kind = SRC_ANALOG_RAIL;
		end else if (code == POS_DIGITAL_RAIL) begin
			kind = SRC_DIGITAL_RAIL;
		end
		return kind;
	endfunction

endpackage

`default_nettype wire

// ### abcfg_gain_dec.sv
`default_nettype none

// Gain code to gain factor; codes 10b and 11b both give four
module abcfg_gain_dec (
	input  wire logic [1:0] code_i,
	output logic      [2:0] gain_o
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	always_comb begin
		if (code_i == abcfg_pkg::GAIN_CODE_X1) begin
			gain_o = abcfg_pkg::GAIN_X1;
		end else if (code_i == abcfg_pkg::GAIN_CODE_X2) begin
			gain_o = abcfg_pkg::GAIN_X2;
		end else begin
			gain_o = abcfg_pkg::GAIN_X4;
		end
	end

endmodule

`default_nettype wire

// ### abcfg_tb_top.sv
`default_nettype none

module abcfg_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// Signals and bench state
	// ----------------------------------------------------------------
	logic        clk_i;
	logic        rst_i;
	logic [7:0]  addr_i;
	logic [15:0] wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [15:0] rdata_o;
	logic        standby_i;
	logic        powerdown_i;
	logic        cur_en_i;
	logic [23:0] vdata_i;
	logic        vvalid_i;
	logic        tick_i;
	logic        step_enable_o;
	logic [2:0]  step_gain_o;
	logic [3:0]  step_pos_sel_o;
	logic [2:0]  step_src_o;
	logic        step_neg_auto_o;
	logic        step_neg_seven_o;
	logic        vconv_enable_o;
	logic [2:0]  vconv_gain_o;
	logic [3:0]  vconv_mux_o;
	logic        ow_source_pin_o;
	logic        ow_sink_pin_o;
	logic [7:0]  ow_source_ua_o;
	logic [7:0]  ow_sink_ua_o;
	logic [23:0] vconv_result_o;
	logic [1:0]  conv_count_o;
	logic [15:0] s_m;
	logic [15:0] v_m;
	logic [15:0] d;
	logic [23:0] r;
	int          seed = 55;
	int          num_errors = 0;
	int          checked = 0;
	int          cnt;

	// Clock, 5 ns period
	initial clk_i = 1'b0;
	always #2.5 clk_i = ~clk_i;

	abcfg_top abcfg_top_i (
		.clk_i               (clk_i),
		.rst_i               (rst_i),
		.addr_i              (addr_i),
		.wdata_i             (wdata_i),
		.wr_i                (wr_i),
		.rd_i                (rd_i),
		.rdata_o             (rdata_o),
		.standby_i           (standby_i),
		.powerdown_i         (powerdown_i),
		.current_conv_b_en_i (cur_en_i),
		.vconv_data_i        (vdata_i),
		.vconv_data_valid_i  (vvalid_i),
		.conv_tick_i         (tick_i),
		.step_enable_o       (step_enable_o),
		.step_gain_o         (step_gain_o),
		.step_pos_sel_o      (step_pos_sel_o),
		.step_src_o          (step_src_o),
		.step_neg_auto_o     (step_neg_auto_o),
		.step_neg_seven_o    (step_neg_seven_o),
		.vconv_enable_o      (vconv_enable_o),
		.vconv_gain_o        (vconv_gain_o),
		.vconv_mux_o         (vconv_mux_o),
		.ow_source_pin_o     (ow_source_pin_o),
		.ow_sink_pin_o       (ow_sink_pin_o),
		.ow_source_ua_o      (ow_source_ua_o),
		.ow_sink_ua_o        (ow_sink_ua_o),
		.vconv_result_o      (vconv_result_o),
		.conv_count_o        (conv_count_o)
	);

	// ----------------------------------------------------------------
	// Expectation functions and shared tasks
	// ----------------------------------------------------------------
	function automatic logic [2:0] eg(input logic [1:0] c);
		return (c == 2'h0) ? 3'h1 : (c == 2'h1) ? 3'h2 : 3'h4;
	endfunction

	function automatic logic [2:0] es(input logic [3:0] c);
		case (c)
			4'h8: return 3'h1;
			4'h9: return 3'h2;
			4'ha: return 3'h3;
			4'he: return 3'h4;
			4'hf: return 3'h5;
			default: return (c < 4'h8) ? 3'h0 : 3'h6;
		endcase
	endfunction

	function automatic logic [7:0] eu(input logic [1:0] c);
		return (c == 2'h0) ? 8'h00 : (c == 2'h1) ? 8'h04 : (c == 2'h2) ? 8'h28 : 8'hf0;
	endfunction

	function automatic logic [15:0] em(input logic [7:0] a);
		return (a == 8'hdf) ? s_m : (a == 8'he0) ? v_m : 16'h0000;
	endfunction

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// One-cycle write; model keeps writable bits only
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= v;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i    <= 1'b0;
		if (a == 8'hdf) s_m = v & 16'he01f;
		if (a == 8'he0) v_m = v & 16'h8f3f;
		#1;
	endtask

	// One-cycle read; data in the next cycle only, then zero
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		#1;
		chk(rdata_o, em(a));
		@(posedge clk_i);
		#1;
		chk(rdata_o, 16'h0000);
	endtask

	// Decoded outputs against both register models
	task automatic chk_cfg();
		chk(step_enable_o, s_m[15]);
		chk(step_gain_o, eg(s_m[14:13]));
		chk(step_pos_sel_o, s_m[3:0]);
		chk(step_src_o, es(s_m[3:0]));
		chk(step_neg_auto_o, s_m[3:0] >= 4'h8);
		chk(step_neg_seven_o, s_m[4] & (s_m[3:0] < 4'h8));
		chk(vconv_enable_o, v_m[15]);
		chk(vconv_gain_o, eg(v_m[11:10]));
		chk(vconv_mux_o, 4'h1 << v_m[9:8]);
		chk(ow_source_pin_o, v_m[5]);
		chk(ow_sink_pin_o, v_m[4]);
		chk(ow_source_ua_o, eu(v_m[3:2]));
		chk(ow_sink_ua_o, eu(v_m[1:0]));
	endtask

	// Pulse a converter-side strobe for one cycle
	task automatic pulse(input logic is_tick, input logic [23:0] v);
		@(posedge clk_i);
		if (is_tick) tick_i <= 1'b1;
		else begin
			vvalid_i <= 1'b1;
			vdata_i  <= v;
		end
		@(posedge clk_i);
		tick_i   <= 1'b0;
		vvalid_i <= 1'b0;
		#1;
	endtask

	// Cycle limit for the whole run
	initial begin
		repeat (100000) @(posedge clk_i);
		num_errors++;
		conclude();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst_i, wr_i, rd_i, standby_i, powerdown_i, vvalid_i, tick_i} = 7'h40;
		addr_i   = 8'h00;
		wdata_i  = 16'h0000;
		cur_en_i = 1'b1;
		vdata_i  = 24'h000000;
		for (int k = 0; k < 2; k++) begin
			repeat (k == 0 ? 12 : 2) @(posedge clk_i);
			rst_i <= 1'b0;
			s_m = 16'h000f;
			v_m = 16'h8010;
			#1;
			chk(vconv_result_o, 24'h000000);
			chk(conv_count_o, 2'h0);
			chk_cfg();
			rd(8'hdf);
			rd(8'he0);
			if (k == 0) begin
				// Every positive select and every converter two-bit code; step gain code random
				for (int i = 0; i < 16; i++) begin
					d = $random(seed);
					d[3:0] = i[3:0];
					wr(8'hdf, d);
					chk_cfg();
					d = $random(seed);
					d[11:8] = {i[1:0], i[3:2]};
					d[3:0] = ~i[3:0];
					wr(8'he0, d);
					chk_cfg();
				end
				// Random mix, unmapped addresses among them
				for (int i = 0; i < 40; i++) begin
					d = $random(seed);
					r = $random(seed);
					wr((r[1:0] == 2'h0) ? r[15:8] : (r[0] ? 8'hdf : 8'he0), d);
					chk_cfg();
					rd(r[1:0] == 2'h3 ? r[23:16] : (r[2] ? 8'hdf : 8'he0));
				end
				// Result zeroing: standby, power-down, disable
				wr(8'he0, 16'h8010);
				for (int c = 0; c < 3; c++) begin
					r = $random(seed);
					pulse(1'b0, r);
					chk(vconv_result_o, r);
					@(posedge clk_i);
					if (c == 0) standby_i <= 1'b1;
					if (c == 1) powerdown_i <= 1'b1;
					if (c == 2) wr(8'he0, 16'h0010);
					repeat (2) @(posedge clk_i);
					#1;
					chk(vconv_result_o, 24'h000000);
					pulse(1'b0, ~r);
					chk(vconv_result_o, 24'h000000);
					@(posedge clk_i);
					standby_i   <= 1'b0;
					powerdown_i <= 1'b0;
					if (c == 2) wr(8'he0, 16'h8010);
				end
				// Counter wraps, clears when both converters are off
				cnt = 0;
				for (int i = 0; i < 5; i++) begin
					pulse(1'b1, 24'h000000);
					cnt = (cnt + 1) % 4;
					chk(conv_count_o, cnt[1:0]);
				end
				@(posedge clk_i);
				cur_en_i <= 1'b0;
				wr(8'he0, 16'h0010);
				@(posedge clk_i);
				#1;
				chk(conv_count_o, 2'h0);
				pulse(1'b1, 24'h000000);
				chk(conv_count_o, 2'h0);
				@(posedge clk_i);
				cur_en_i <= 1'b1;
				repeat (2) @(posedge clk_i);
				pulse(1'b1, 24'h000000);
				chk(conv_count_o, 2'h1);
				@(posedge clk_i);
				rst_i <= 1'b1;
			end
		end
		conclude();
	end
endmodule

`default_nettype wire
